// File: core/ldr_cfg.svh
// constants for the legacy decode and routing block: offsets, fields, resets, ports
`ifndef LDR_CFG_SVH
`define LDR_CFG_SVH

// register indices; byte address is four times the index
`define LDR_IDX_LEGACY      8'h41
`define LDR_IDX_ROM         8'h43
`define LDR_IDX_PREFETCH    8'h44
`define LDR_IDX_STATUS      8'h45

// reset values
`define LDR_RST_LEGACY      8'h07
`define LDR_RST_ROM         8'h00
`define LDR_RST_PREFETCH    16'h0001

// writable bit masks, all other bits reserved
`define LDR_MASK_LEGACY     8'h07
`define LDR_MASK_ROM        8'hFF
`define LDR_MASK_PREFETCH   16'hFFF1

// field positions
`define LDR_BIT_INTC_EN     0
`define LDR_BIT_TIMER_EN    1
`define LDR_BIT_DMA_EN      2
`define LDR_BIT_PREFETCH_EVERYTHING       0
`define LDR_BIT_ROM_4M      7
`define LDR_BIT_ROM_1M      6
`define LDR_CEIL_LSB        4
`define LDR_CEIL_MSB        15
`define LDR_SEG_COUNT       6

// address ranges and translation
`define LDR_ROM_4M_TAG      10'h3FF
`define LDR_ROM_1M_TAG      12'hFFB
`define LDR_SEG_BASE_TAG    17'h00018
`define LDR_HIGH_64K_TAG    16'hFFFF
`define LDR_LOW_64K_TAG     16'h000F
`define LDR_LPC_TOP12       12'hFFF

// legacy io ports
`define LDR_P_TMR_STAT0     16'h0040
`define LDR_P_TMR_STAT1     16'h0041
`define LDR_P_TMR_STAT2     16'h0042
`define LDR_P_TMR_CTRL      16'h0043
`define LDR_P_SPEAKER       16'h0061
`define LDR_P_INTC1_A       16'h0020
`define LDR_P_INTC1_B       16'h0021
`define LDR_P_INTC2_A       16'h00A0
`define LDR_P_INTC2_B       16'h00A1
`define LDR_P_FAST_A20      16'h0092
`define LDR_P_COPRO_0       16'h00F0
`define LDR_P_COPRO_1       16'h00F1
`define LDR_P_ELCR_0        16'h04D0
`define LDR_P_ELCR_1        16'h04D1

// pci read commands
`define LDR_CMD_MEM_RD      4'h6
`define LDR_CMD_RD_MULT     4'hC
`define LDR_CMD_RD_LINE     4'hE

// read-back sequence last step indices
`define LDR_TMR_SEQ_LAST    3'h6
`define LDR_INTC_SEQ_LAST   4'hC

`endif

// File: core/ldr_pkg.sv
// types shared by the legacy decode and routing block
package ldr_pkg;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_DMA, TGT_TIMER, TGT_INTC, TGT_LPC_IO, TGT_LPC_ROM, TGT_MEM
  } ldr_target_e;

  typedef struct packed {
    logic        valid;
    logic        io;
    logic        inta;
    logic [31:0] addr;
  } ldr_host_req_s;

  typedef struct packed {
    logic        valid;
    ldr_target_e target;
    logic [31:0] lpc_addr;
  } ldr_route_s;

  typedef struct packed {
    logic [2:0][7:0] status;
    logic [2:0][7:0] count_lo;
    logic [2:0][7:0] count_hi;
  } ldr_timer_s;

  typedef struct packed {
    logic [7:0]      irr1;
    logic [7:0]      isr1;
    logic [7:0]      irr2;
    logic [7:0]      isr2;
    logic [3:0][7:0] init_control_word;
    logic [1:0][7:0] operation_control_word;
    logic [3:0][7:0] icw2;
    logic [2:0][7:0] ocw2;
  } ldr_intc_s;

endpackage

// File: core/ldr_readback.sv
// read-back data path for timer and interrupt controller state
`timescale 1ns/1ps
`include "ldr_cfg.svh"

module ldr_readback
  import ldr_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // io read request
  input  wire logic       io_rd,
  input  wire logic [15:0] io_port,
  input  wire logic       rb_mode,
  input  wire logic       claim_timer,
  input  wire logic       claim_intc,
  // unit state
  input  wire ldr_timer_s timer_st,
  input  wire ldr_intc_s  intc_st,
  // answer
  output logic            rd_valid_q,
  output logic [7:0]      rd_data_q
);

  logic [2:0] tseq_q;
  logic [3:0] iseq_q;
  logic       hit_t40, hit_t41, hit_t42, hit_i20, hit_i21, hit_ia0, hit_ia1;
  logic       hit;
  logic [7:0] data_d;

  // timer read-back order: status0, then low/high bytes of counters 0..2
  function automatic logic [7:0] tmr_word(input ldr_timer_s s, input logic [2:0] i);
    case (i)
      3'h0:    tmr_word = s.status[0];
      3'h1:    tmr_word = s.count_lo[0];
      3'h2:    tmr_word = s.count_hi[0];
      3'h3:    tmr_word = s.count_lo[1];
      3'h4:    tmr_word = s.count_hi[1];
      3'h5:    tmr_word = s.count_lo[2];
      3'h6:    tmr_word = s.count_hi[2];
      default: tmr_word = 8'h00;
    endcase
  endfunction

  // controller read-back order: ctrl1 init 1-4, op 1-2, ctrl2 init 1-4, op 1-3
  function automatic logic [7:0] intc_word(input ldr_intc_s s, input logic [3:0] i);
    if (i < 4'h4) begin
      intc_word = s.init_control_word[i[1:0]];
    end else if (i < 4'h6) begin
      intc_word = s.operation_control_word[i[0]];
    end else if (i < 4'hA) begin
      intc_word = s.icw2[2'(i - 4'h6)];
    end else begin
      intc_word = s.ocw2[2'(i - 4'hA)];
    end
  endfunction

  assign hit_t40 = claim_timer && (io_port == `LDR_P_TMR_STAT0);
  assign hit_t41 = claim_timer && (io_port == `LDR_P_TMR_STAT1);
  assign hit_t42 = claim_timer && (io_port == `LDR_P_TMR_STAT2);
  assign hit_i20 = claim_intc && (io_port == `LDR_P_INTC1_A);
  assign hit_i21 = claim_intc && (io_port == `LDR_P_INTC1_B);
  assign hit_ia0 = claim_intc && (io_port == `LDR_P_INTC2_A);
  assign hit_ia1 = claim_intc && (io_port == `LDR_P_INTC2_B);
  assign hit = hit_t40 | hit_t41 | hit_t42 | hit_i20 | hit_i21 | hit_ia0 | hit_ia1;

  // data select; the stepped ports only step while read-back mode is on
  always_comb begin
    data_d = 8'h00;
    if (hit_t40) begin
      data_d = rb_mode ? tmr_word(timer_st, tseq_q) : timer_st.status[0];
    end else if (hit_t41) begin
      data_d = timer_st.status[1];
    end else if (hit_t42) begin
      data_d = timer_st.status[2];
    end else if (hit_i20) begin
      data_d = rb_mode ? intc_word(intc_st, iseq_q) : intc_st.irr1;
    end else if (hit_i21) begin
      data_d = intc_st.isr1;
    end else if (hit_ia0) begin
      data_d = intc_st.irr2;
    end else if (hit_ia1) begin
      data_d = intc_st.isr2;
    end
  end

  // timer step counter, wraps after the seventh read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tseq_q <= 3'h0;
    end else if (!rb_mode) begin
      tseq_q <= 3'h0;
    end else if (io_rd && hit_t40) begin
      tseq_q <= (tseq_q == `LDR_TMR_SEQ_LAST) ? 3'h0 : tseq_q + 3'h1;
    end
  end

  // controller step counter, wraps after the last operation word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iseq_q <= 4'h0;
    end else if (!rb_mode) begin
      iseq_q <= 4'h0;
    end else if (io_rd && hit_i20) begin
      iseq_q <= (iseq_q == `LDR_INTC_SEQ_LAST) ? 4'h0 : iseq_q + 4'h1;
    end
  end

  // registered answer, one cycle after the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
    end else begin
      rd_valid_q <= io_rd && hit;
      if (io_rd && hit) begin
        rd_data_q <= data_d;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tmr_second;
    io_rd && hit_t40 && rb_mode && tseq_q == 3'h1;
  endsequence

  a_timer_low0: assert property (s_tmr_second |=> rd_data_q == $past(timer_st.count_lo[0]))
    else $error("second timer read-back is not counter 0 low byte");
  a_timer_stat1: assert property (io_rd && hit_t41 |=> rd_valid_q && rd_data_q == $past(timer_st.status[1]))
    else $error("port 41h did not return counter 1 status");
  a_intc_seq: assert property (io_rd && hit_i20 && rb_mode && iseq_q == 4'h6
                               |=> rd_data_q == $past(intc_st.icw2[0]))
    else $error("seventh controller read-back is not ctrl2 first init word");
  a_intc_isr1: assert property (io_rd && hit_i21 |=> rd_data_q == $past(intc_st.isr1))
    else $error("port 21h did not return first in-service register");
  a_intc_two: assert property (io_rd && hit_ia1 |=> rd_data_q == $past(intc_st.isr2))
    else $error("port A1h did not return second in-service register");

endmodule

// File: core/ldr_top.sv
// legacy io/memory decode, bios rom translation, prefetch decision and apb registers
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "ldr_cfg.svh"

module ldr_top
  import ldr_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // host cycle decode
  input  wire ldr_host_req_s host_req,
  output ldr_route_s         route_q,
  // pci master read prefetch decision
  input  wire logic          pci_valid,
  input  wire logic [3:0]    pci_cmd,
  input  wire logic [31:0]   pci_addr,
  output logic               pf_valid_q,
  output logic               pf_ok_q,
  // legacy read-back
  input  wire logic          io_rd,
  input  wire logic [15:0]   io_port,
  input  wire logic          rb_mode,
  input  wire ldr_timer_s    timer_st,
  input  wire ldr_intc_s     intc_st,
  output logic               rd_valid_q,
  output logic [7:0]         rd_data_q
);

  localparam logic [ADDR_W-1:0] A_LEGACY   = ADDR_W'({`LDR_IDX_LEGACY, 2'b00});
  localparam logic [ADDR_W-1:0] A_ROM      = ADDR_W'({`LDR_IDX_ROM, 2'b00});
  localparam logic [ADDR_W-1:0] A_PREFETCH = ADDR_W'({`LDR_IDX_PREFETCH, 2'b00});
  localparam logic [ADDR_W-1:0] A_STATUS   = ADDR_W'({`LDR_IDX_STATUS, 2'b00});

  // the register map needs byte addresses up to 114h
  initial begin
    if (ADDR_W < 10 || ADDR_W > 32) begin
      $error("ldr_top: ADDR_W must be between 10 and 32");
    end
  end

  logic [7:0]  legacy_q;
  logic [7:0]  rom_q;
  logic [15:0] pf_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        wr_en;
  logic        setup;
  logic        hit_any;
  logic [31:0] rd_mux;
  ldr_route_s  route_d;
  logic        pf_d;
  logic        dma_en, timer_en, intc_en, prefetch_everything;
  logic [11:0] ceiling;

  // range test shared by the dma and timer port decoders below
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic is_dma_port(input logic [15:0] p);
    is_dma_port = in_range(p, 16'h0000, 16'h000F) || in_range(p, 16'h0080, 16'h008F) ||
                  in_range(p, 16'h00C0, 16'h00DF);
  endfunction

  function automatic logic is_timer_port(input logic [15:0] p);
    is_timer_port = in_range(p, `LDR_P_TMR_STAT0, `LDR_P_TMR_CTRL) || (p == `LDR_P_SPEAKER);
  endfunction

  function automatic logic is_intc_port(input logic [15:0] p);
    is_intc_port = (p == `LDR_P_INTC1_A) || (p == `LDR_P_INTC1_B) ||
                   (p == `LDR_P_FAST_A20) || (p == `LDR_P_INTC2_A) ||
                   (p == `LDR_P_INTC2_B) || (p == `LDR_P_COPRO_0) ||
                   (p == `LDR_P_COPRO_1) || (p == `LDR_P_ELCR_0) || (p == `LDR_P_ELCR_1);
  endfunction

  assign dma_en   = legacy_q[`LDR_BIT_DMA_EN];
  assign timer_en = legacy_q[`LDR_BIT_TIMER_EN];
  assign intc_en  = legacy_q[`LDR_BIT_INTC_EN];
  assign prefetch_everything    = pf_q[`LDR_BIT_PREFETCH_EVERYTHING];
  assign ceiling  = pf_q[`LDR_CEIL_MSB:`LDR_CEIL_LSB];

  // apb decode; zero wait states, data registered during the setup cycle
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && !pslverr_q;
  assign hit_any = (paddr == A_LEGACY) || (paddr == A_ROM) || (paddr == A_PREFETCH) ||
                   (paddr == A_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && pslverr_q;
  assign prdata  = prdata_q;

  // read mux; reserved bits come back as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      A_LEGACY:   rd_mux = {24'h00_0000, legacy_q & `LDR_MASK_LEGACY};
      A_ROM:      rd_mux = {24'h00_0000, rom_q};
      A_PREFETCH: rd_mux = {16'h0000, pf_q & `LDR_MASK_PREFETCH};
      A_STATUS:   rd_mux = {23'h00_0000, pf_ok_q, 5'h00, route_q.target};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // read data and error flag latched in setup, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= !hit_any;
    end
  end

  // legacy unit enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legacy_q <= `LDR_RST_LEGACY;
    end else if (wr_en && paddr == A_LEGACY) begin
      legacy_q <= pwdata[7:0] & `LDR_MASK_LEGACY;
    end
  end

  // rom window enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_q <= `LDR_RST_ROM;
    end else if (wr_en && paddr == A_ROM) begin
      rom_q <= pwdata[7:0];
    end
  end

  // prefetch control: ceiling plus prefetch-everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_q <= `LDR_RST_PREFETCH;
    end else if (wr_en && paddr == A_PREFETCH) begin
      pf_q <= pwdata[15:0] & `LDR_MASK_PREFETCH;
    end
  end

  // host cycle classification; fixed bios windows win over the enable bits
  always_comb begin
    route_d          = '0;
    route_d.valid    = host_req.valid;
    route_d.target   = TGT_NONE;
    route_d.lpc_addr = host_req.addr;
    if (!host_req.valid) begin
      route_d.target = TGT_NONE;
    end else if (host_req.inta) begin
      route_d.target = intc_en ? TGT_INTC : TGT_LPC_IO;
    end else if (host_req.io) begin
      route_d.target = TGT_LPC_IO;
      if (is_dma_port(host_req.addr[15:0])) begin
        route_d.target = dma_en ? TGT_DMA : TGT_LPC_IO;
      end else if (is_timer_port(host_req.addr[15:0])) begin
        route_d.target = timer_en ? TGT_TIMER : TGT_LPC_IO;
      end else if (is_intc_port(host_req.addr[15:0])) begin
        route_d.target = intc_en ? TGT_INTC : TGT_LPC_IO;
      end
    end else if (host_req.addr[31:16] == `LDR_HIGH_64K_TAG) begin
      route_d.target = TGT_LPC_ROM;
    end else if (host_req.addr[31:16] == `LDR_LOW_64K_TAG) begin
      route_d.target   = TGT_LPC_ROM;
      route_d.lpc_addr = {`LDR_HIGH_64K_TAG, host_req.addr[15:0]};
    end else if (rom_q[`LDR_BIT_ROM_4M] && host_req.addr[31:22] == `LDR_ROM_4M_TAG) begin
      route_d.target = TGT_LPC_ROM;
    end else if (rom_q[`LDR_BIT_ROM_1M] && host_req.addr[31:20] == `LDR_ROM_1M_TAG) begin
      route_d.target = TGT_LPC_ROM;
    end else begin
      route_d.target = TGT_MEM;
      for (int i = 0; i < `LDR_SEG_COUNT; i++) begin
        if (rom_q[i] && host_req.addr[31:15] == 17'(`LDR_SEG_BASE_TAG + i)) begin
          route_d.target   = TGT_LPC_ROM;
          route_d.lpc_addr = {`LDR_LPC_TOP12, host_req.addr[19:0]};
        end
      end
    end
  end

  // routing result, one cycle after the host request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= '0;
    end else begin
      route_q <= route_d;
    end
  end

  // prefetch decision for pci master reads
  always_comb begin
    pf_d = 1'b0;
    case (pci_cmd)
      `LDR_CMD_RD_MULT: pf_d = 1'b1;
      `LDR_CMD_RD_LINE: pf_d = 1'b1;
      `LDR_CMD_MEM_RD:  pf_d = prefetch_everything || (pci_addr[31:20] < ceiling);
      default:          pf_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_valid_q <= 1'b0;
      pf_ok_q    <= 1'b0;
    end else begin
      pf_valid_q <= pci_valid;
      if (pci_valid) begin
        pf_ok_q <= pf_d;
      end
    end
  end

  // read-back only answers ports that the enabled internal units own
  ldr_readback u_readback (
    .pclk        (pclk),
    .presetn     (presetn),
    .io_rd       (io_rd),
    .io_port     (io_port),
    .rb_mode     (rb_mode),
    .claim_timer (timer_en),
    .claim_intc  (intc_en),
    .timer_st    (timer_st),
    .intc_st     (intc_st),
    .rd_valid_q  (rd_valid_q),
    .rd_data_q   (rd_data_q)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_io_req(logic [15:0] p);
    host_req.valid && host_req.io && !host_req.inta && host_req.addr[15:0] == p;
  endsequence

  a_dma_route: assert property (s_io_req(16'h0085) |=> route_q.target == ($past(dma_en) ? TGT_DMA : TGT_LPC_IO))
    else $error("dma port routed wrongly");
  a_timer_route: assert property (s_io_req(16'h0061) |=> route_q.target == ($past(timer_en) ? TGT_TIMER : TGT_LPC_IO))
    else $error("timer port routed wrongly");
  a_intc_ack: assert property (host_req.valid && host_req.inta |=> route_q.target == ($past(intc_en) ? TGT_INTC : TGT_LPC_IO))
    else $error("interrupt acknowledge routed wrongly");
  a_legacy_reset: assert property ($past(!presetn) |-> legacy_q == 8'h07)
    else $error("legacy enables not 07h after reset");
  a_seg_translate: assert property (host_req.valid && !host_req.io && !host_req.inta && rom_q[0]
                                    && host_req.addr[31:15] == 17'h00018
                                    |=> route_q.target == TGT_LPC_ROM
                                        && route_q.lpc_addr[31:20] == 12'hFFF)
    else $error("segment 0 not translated to lpc rom");
  a_rom_1m: assert property (host_req.valid && !host_req.io && !host_req.inta && !rom_q[6]
                             && host_req.addr[31:20] == 12'hFFB
                             |=> route_q.target == TGT_MEM)
    else $error("disabled 1 MB window still decoded");
  a_fixed_rom: assert property (host_req.valid && !host_req.io && !host_req.inta
                                && host_req.addr[31:16] == 16'h000F
                                |=> route_q.target == TGT_LPC_ROM
                                    && route_q.lpc_addr == {16'hFFFF, $past(host_req.addr[15:0])})
    else $error("low 64K bios window not shown at top");
  a_ceiling_hold: assert property (wr_en && paddr == A_PREFETCH |=> ceiling == $past(pwdata[15:4]))
    else $error("ceiling field did not take written value");
  a_prefetch_all: assert property (pci_valid && pci_cmd == 4'h6 && prefetch_everything |=> pf_valid_q && pf_ok_q)
    else $error("prefetch-everything did not prefetch command 6h");
  a_cmd_filter: assert property (pci_valid && pci_cmd != 4'h6 && pci_cmd != 4'hC && pci_cmd != 4'hE
                                 |=> !pf_ok_q)
    else $error("non-read command marked prefetchable");
  a_reserved_zero: assert property (legacy_q[7:3] == 5'h00 && pf_q[3:1] == 3'h0)
    else $error("reserved bits became set");

endmodule

// File: tb/ldr_unit_model.sv
// behavioural model of the legacy timer and interrupt controller state seen by the block
`timescale 1ns/1ps

module ldr_unit_model
  import ldr_pkg::*;
(
  // clock and update strobe
  input  wire logic pclk,
  input  wire logic shuffle,
  // unit state
  output ldr_timer_s timer_st,
  output ldr_intc_s  intc_st
);
  int seed = 32'h0000_5A17;

  // new counter and controller contents on each strobe; levels hold in between
  always @(posedge pclk) begin
    if (shuffle) begin
      timer_st <= 72'({$random(seed), $random(seed), $random(seed)});
      intc_st  <= 136'({$random(seed), $random(seed), $random(seed), $random(seed),
                        $random(seed)});
    end
  end
endmodule

// File: tb/tb.sv
// self-checking bench for the legacy decode and routing block
`timescale 1ns/1ps

module tb
  import ldr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic pci_valid, pf_valid_q, pf_ok_q, io_rd, rb_mode, rd_valid_q, shuffle;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pci_addr, rd;
  logic [3:0]  pci_cmd;
  logic [15:0] io_port, pfc;
  logic [7:0]  rd_data_q, leg, rom;
  ldr_host_req_s host_req;
  ldr_route_s    route_q;
  ldr_timer_s    timer_st;
  ldr_intc_s     intc_st;
  int err_total, total_checks, cyc, seed, i, k;
  logic [15:0] ports [24] = '{16'h00, 16'h0F, 16'h10, 16'h80, 16'h8F, 16'h90, 16'hC0, 16'hDF,
    16'hE0, 16'h3F, 16'h40, 16'h43, 16'h44, 16'h61, 16'h20, 16'h21, 16'h92, 16'hA0, 16'hA1,
    16'hF0, 16'hF1, 16'h4D0, 16'h4D1, 16'h22};
  logic [31:0] mems [14] = '{32'hFFFF_0000, 32'hFFC0_0000, 32'hFFEF_FFFF, 32'hFFB0_0000,
    32'hFFBF_FFFF, 32'hFFAF_FFFF, 32'h000C_0000, 32'h000C_8000, 32'h000D_7FFF, 32'h000E_8000,
    32'h000E_FFFF, 32'h000F_1234, 32'h000B_FFFF, 32'h0010_0000};

  ldr_top #(.ADDR_W(12)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .host_req, .route_q, .pci_valid, .pci_cmd, .pci_addr,
    .pf_valid_q, .pf_ok_q, .io_rd, .io_port, .rb_mode, .timer_st, .intc_st, .rd_valid_q,
    .rd_data_q);
  ldr_unit_model far (.pclk, .shuffle, .timer_st, .intc_st);

  // clock at 25 MHz
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // apb master: request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // expected target and lpc address of a host cycle
  function automatic logic [34:0] exp_route(logic io, logic ia, logic [31:0] a);
    ldr_target_e t;
    logic [31:0] la;
    logic [4:0]  s;
    s = a[19:15] - 5'h18;
    la = a;
    t = (io | ia) ? TGT_LPC_IO : TGT_MEM;
    if (io && leg[2] && (a[15:4] == 12'h000 || a[15:4] == 12'h008 || a[15:5] == 11'h006)) t = TGT_DMA;
    if (io && leg[1] && (a[15:2] == 14'h0010 || a[15:0] == 16'h0061)) t = TGT_TIMER;
    if (leg[0] && (ia || io && a[15:0] inside {16'h20, 16'h21, 16'h92, 16'hA0, 16'hA1, 16'hF0,
      16'hF1, 16'h4D0, 16'h4D1})) t = TGT_INTC;
    if (!(io | ia)) begin
      if (rom[7] && a[31:22] == 10'h3FF || rom[6] && a[31:20] == 12'hFFB) t = TGT_LPC_ROM;
      if (a[31:20] == 12'h000 && s < 5'h06 && rom[s[2:0]]) begin
        t = TGT_LPC_ROM;
        la = {12'hFFF, a[19:0]};
      end
      if (a[31:16] == 16'hFFFF) t = TGT_LPC_ROM;
      if (a[31:16] == 16'h000F) begin
        t = TGT_LPC_ROM;
        la = {16'hFFFF, a[15:0]};
      end
    end
    return {t, la};
  endfunction

  task automatic host(input logic io, input logic ia, input logic [31:0] a);
    logic [34:0] x;
    x = exp_route(io, ia, a);
    @(posedge pclk);
    host_req <= '{valid: 1'b1, io: io, inta: ia, addr: a};
    @(posedge pclk);
    host_req.valid <= 1'b0;
    #1;
    check(route_q.valid, 1'b1);
    check(route_q.target, x[34:32]);
    if (!(io | ia)) check(route_q.lpc_addr, x[31:0]);
  endtask

  task automatic pf(input logic [3:0] c, input logic [31:0] a);
    @(posedge pclk);
    {pci_valid, pci_cmd, pci_addr} <= {1'b1, c, a};
    @(posedge pclk);
    pci_valid <= 1'b0;
    #1;
    check(pf_valid_q, 1'b1);
    check(pf_ok_q, c == 4'hC || c == 4'hE || c == 4'h6 && (pfc[0] || a[31:20] < pfc[15:4]));
  endtask

  task automatic rdb(input logic [15:0] p, input logic [7:0] x);
    @(posedge pclk);
    {io_rd, io_port} <= {1'b1, p};
    @(posedge pclk);
    io_rd <= 1'b0;
    #1;
    check(rd_valid_q, 1'b1);
    check(rd_data_q, x);
  endtask

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pci_valid, pci_cmd, pci_addr} = '0;
    {io_rd, io_port, rb_mode, host_req} = '0;
    shuffle = 1'b1;
    seed = 32'h4201;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    shuffle <= 1'b0;
    #1;
    check(route_q, '0);
    apb(1'b0, 12'h104, 32'h0);
    check(rd, 32'h07);
    apb(1'b0, 12'h110, 32'h0);
    check(rd, 32'h0001);
    apb(1'b1, 12'h200, 32'hFFFF_FFFF);
    check(e, 1'b1);
    apb(1'b1, 12'h110, 32'hFFFF_FFFF);
    apb(1'b0, 12'h110, 32'h0);
    check(rd, 32'hFFF1);
    // every enable combination against every legacy port edge
    for (k = 0; k < 8; k++) begin
      leg = 8'hF8 | k[7:0];
      apb(1'b1, 12'h104, {24'h0, leg});
      leg = k[7:0];
      apb(1'b0, 12'h104, 32'h0);
      check(rd, {24'h0, leg});
      foreach (ports[i]) host(1'b1, 1'b0, {16'h0, ports[i]});
      host(1'b0, 1'b1, 32'h0);
    end
    for (k = 0; k < 6; k++) begin
      rom = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : $random(seed);
      apb(1'b1, 12'h10C, {24'h0, rom});
      apb(1'b0, 12'h10C, 32'h0);
      check(rd, {24'h0, rom});
      check(e, 1'b0);
      foreach (mems[i]) host(1'b0, 1'b0, mems[i]);
      host(1'b0, 1'b0, {12'h000, 2'b11, 18'($random(seed))});
      host(1'b0, 1'b0, $random(seed));
    end
    for (k = 0; k < 8; k++) begin
      pfc = 16'($random(seed)) & 16'hFFF1;
      apb(1'b1, 12'h110, {16'h0, pfc});
      for (i = 0; i < 16; i++) pf(i[3:0], $random(seed));
      pf(4'h6, {pfc[15:4], 20'h0});
      pf(4'h6, {pfc[15:4] - 12'h001, 20'hFFFFF});
    end
    apb(1'b1, 12'h104, 32'h07);
    // both read modes; step counters restart whenever read-back mode drops
    for (k = 0; k < 2; k++) begin
      rb_mode <= k[0];
      rdb(16'h41, timer_st.status[1]);
      rdb(16'h42, timer_st.status[2]);
      rdb(16'h21, intc_st.isr1);
      rdb(16'hA0, intc_st.irr2);
      rdb(16'hA1, intc_st.isr2);
    end
    rdb(16'h40, timer_st.status[0]);
    for (i = 1; i < 7; i++) rdb(16'h40, i[0] ? timer_st.count_lo[i/2] : timer_st.count_hi[i/2-1]);
    for (i = 0; i < 13; i++) rdb(16'h20, (i < 4) ? intc_st.init_control_word[i] : (i < 6) ? intc_st.operation_control_word[i-4]
      : (i < 10) ? intc_st.icw2[i-6] : intc_st.ocw2[i-10]);
    rb_mode <= 1'b0;
    rdb(16'h20, intc_st.irr1);
    give_verdict();
  end
endmodule
